// ### dv/caf_engine_model.sv
// Behavioural protocol engine that hands received identifiers to the bank.
// Assumes the bench pulses i_send for one cycle per frame.
`timescale 1ns/1ps
`default_nettype none
module caf_engine_model (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_sys_rst,
  // Frame request from the bench
  input  wire logic                   i_send,
  input  wire caf_pkg::caf_frame_type i_req,
  // Frame to the bank
  output var caf_pkg::caf_frame_type  o_frame
);
  import caf_pkg::*;
  // Between frames the ids toggle, so a stale id never passes for a match.
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_frame <= '0;
    end else if (i_send) begin
      o_frame <= {1'b1, i_req.is_ext, i_req.std_id, i_req.ext_id};
    end else begin
      o_frame <= {1'b0, ~o_frame.is_ext, ~o_frame.std_id, ~o_frame.ext_id};
    end
  end
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the acceptance filter bank.
// Assumes the engine model file and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import caf_pkg::*;
  // ==========================================================================
  // Signals
  logic          clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, send = 0;
  logic [11:0]   paddr = '0;
  logic [31:0]   pwdata = '0, prdata;
  logic          pready, pslverr, acc_v;
  logic [15:0]   hits, last;
  caf_frame_type req = '0, frame;
  logic [15:0]   sp [16], ep [16], ms, me;
  int            fail_count = 0, cmp_count = 0;
  always #5 clk = ~clk;
  caf_engine_model i_caf_engine_model (.i_mclk(clk), .i_sys_rst(rst),
    .i_send(send), .i_req(req), .o_frame(frame));
  caf_filter_bank #(.NUM_FILTERS(16)) i_caf_filter_bank (.i_mclk(clk),
    .i_sys_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_frame(frame),
    .o_accept_valid(acc_v), .o_accept_hits(hits));
  // ==========================================================================
  // Helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] q, output logic e);
    int k;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin fail_count++; tally_and_finish; end
    q = prdata;
    e = pslverr;
    psel <= 0; pen <= 0;
  endtask
  // Upper half of the write word is set to show it is ignored.
  task wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] q; logic e;
    apb(1, a, {16'hFFFF, d}, q, e);
    check(e, 0);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q; logic e;
    apb(0, a, 32'h0, q, e);
    check(q, x);
    check(e, xe);
  endtask
  function logic [15:0] exp_hits(caf_frame_type f);
    logic [15:0] h;
    for (int n = 0; n < 16; n++) begin
      h[n] = (((f.std_id ^ sp[n][15:5]) & ms[15:5]) == 0)
        && !(ms[3] && sp[n][3] != f.is_ext)
        && !(f.is_ext && (((f.ext_id ^ {sp[n][1:0], ep[n]})
                           & {ms[1:0], me}) != 0));
    end
    return h;
  endfunction
  task frame_t(input caf_frame_type f);
    int k;
    send <= 1; req <= f;
    @(posedge clk);
    send <= 0;
    k = 0;
    do begin @(posedge clk); k++; end while (acc_v !== 1'b1 && k < 8);
    last = exp_hits(f);
    check(acc_v, 1);
    check(hits, last);
    if (acc_v !== 1'b1) tally_and_finish;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    caf_frame_type f;
    int k, j;
    logic [11:0] a;
    void'($urandom(32'h5C20));
    repeat (8) @(posedge clk);
    rst <= 0;
    rd(CAF_STD_OFS, 0, 0);
    rd(12'h07C, 0, 0);
    rd(12'h0FC, 0, 1);
    $display("test reset done");
    for (int n = 0; n < 16; n++) begin
      a = 12'(n) * CAF_FILTER_STRIDE;
      sp[n] = 16'($urandom);
      ep[n] = 16'($urandom);
      wr(CAF_STD_OFS + a, sp[n]);
      wr(CAF_EXT_OFS + a, ep[n]);
      sp[n] &= CAF_STD_WMASK;
    end
    for (int n = 0; n < 16; n++) begin
      a = 12'(n) * CAF_FILTER_STRIDE;
      rd(CAF_STD_OFS + a, {16'h0, sp[n]}, 0);
      rd(CAF_EXT_OFS + a, {16'h0, ep[n]}, 0);
    end
    $display("test registers done");
    // Mode 3 compares every bit; mode 4 opens every filter at once.
    for (int m = 0; m < 5; m++) begin
      ms = 16'($urandom);
      ms[3] = m[0];
      me = 16'($urandom);
      if (m == 3) begin
        ms = 16'hFFEB;
        me = 16'hFFFF;
      end else if (m == 4) begin
        ms = 16'h0000;
        me = 16'h0000;
      end
      wr(CAF_MASK_STD_OFS, ms);
      wr(CAF_MASK_EXT_OFS, me);
      repeat (24) begin
        k = $urandom_range(15);
        f.valid = 1;
        f.is_ext = 1'($urandom);
        f.std_id = sp[k][15:5]; f.ext_id = {sp[k][1:0], ep[k]};
        if ($urandom_range(1)) begin j = $urandom_range(28); f[j] = ~f[j]; end
        frame_t(f);
      end
      rd(CAF_RESULT_OFS, {16'h0, last}, 0);
      $display("test mask mode %0d done", m);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ### hdl/caf_filter_bank.sv
// Acceptance filter identifier match bank with APB register access.
// Assumes the protocol engine presents frames on i_mclk for one cycle.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module caf_filter_bank #(
  parameter int NUM_FILTERS = 16
) (
  // Clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_sys_rst,
  // APB slave
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [11:0]            i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic [31:0]                 o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  // Protocol engine
  input  wire caf_pkg::caf_frame_type i_frame,
  // Result
  output logic                        o_accept_valid,
  output logic [NUM_FILTERS-1:0]      o_accept_hits
);
  import caf_pkg::*;

  if (NUM_FILTERS < 1 || NUM_FILTERS > CAF_NUM_FILTERS) begin : g_bad_num
    $error("NUM_FILTERS out of range");
  end

  // ==========================================================================
  // Register storage
  logic [15:0]            std_r [NUM_FILTERS];
  logic [15:0]            ext_r [NUM_FILTERS];
  logic [15:0]            mask_std_r;
  logic [15:0]            mask_ext_r;
  logic [NUM_FILTERS-1:0] hit_r;
  logic                   acc_r;
  logic [31:0]            rdata_r;
  logic                   ready_r;
  logic                   err_r;

  // ==========================================================================
  // Address decode
  logic        access;
  logic        wr_en;
  logic [11:0] rel;
  logic [3:0]  fidx;
  logic        in_bank;
  logic        is_std;
  logic        is_ext;
  logic        hit_mstd;
  logic        hit_mext;
  logic        hit_res;
  logic        mapped;

  assign access   = i_psel && i_penable && !ready_r;
  // Writes land on the completing edge, when the master sees pready high.
  assign wr_en    = i_psel && i_penable && ready_r && i_pwrite;
  assign rel      = i_paddr & 12'h07F;
  assign fidx     = rel[6:3];
  assign in_bank  = (i_paddr < CAF_MASK_STD_OFS) &&
                    (int'(fidx) < NUM_FILTERS);
  assign is_std   = in_bank && (rel[2:0] == CAF_STD_OFS[2:0]);
  assign is_ext   = in_bank && (rel[2:0] == CAF_EXT_OFS[2:0]);
  assign hit_mstd = i_paddr == CAF_MASK_STD_OFS;
  assign hit_mext = i_paddr == CAF_MASK_EXT_OFS;
  assign hit_res  = i_paddr == CAF_RESULT_OFS;
  assign mapped   = is_std || is_ext || hit_mstd || hit_mext || hit_res;

  // ==========================================================================
  // Read mux
  logic [31:0] rd_val;
  assign rd_val = is_std   ? {16'h0000, std_r[fidx] & CAF_STD_WMASK} :
                  is_ext   ? {16'h0000, ext_r[fidx]} :
                  hit_mstd ? {16'h0000, mask_std_r} :
                  hit_mext ? {16'h0000, mask_ext_r} :
                  hit_res  ? {{(32-NUM_FILTERS){1'b0}}, hit_r} :
                  32'h0000_0000;

  // ==========================================================================
  // Filter comparators
  logic [NUM_FILTERS-1:0] hit_nxt;
  for (genvar g = 0; g < NUM_FILTERS; g++) begin : g_flt
    caf_match u_match (
      .i_std_pat  (std_r[g]),
      .i_ext_pat  (ext_r[g]),
      .i_mask_std (mask_std_r),
      .i_mask_ext (mask_ext_r),
      .i_frame    (i_frame),
      .o_hit      (hit_nxt[g])
    );
  end

  // ==========================================================================
  // Register writes
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < NUM_FILTERS; i++) begin
        std_r[i] <= CAF_PATTERN_RST;
        ext_r[i] <= CAF_PATTERN_RST;
      end
      mask_std_r <= CAF_PATTERN_RST;
      mask_ext_r <= CAF_PATTERN_RST;
    end else if (wr_en) begin
      if (is_std) begin
        std_r[fidx] <= i_pwdata[15:0] & CAF_STD_WMASK;
      end
      if (is_ext) begin
        ext_r[fidx] <= i_pwdata[15:0];
      end
      if (hit_mstd) begin
        mask_std_r <= i_pwdata[15:0];
      end
      if (hit_mext) begin
        mask_ext_r <= i_pwdata[15:0];
      end
    end
  end

  // ==========================================================================
  // APB answer, one wait state: pready rises the cycle after penable
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ready_r <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ready_r <= access;
      err_r   <= access && !mapped;
      rdata_r <= (access && !i_pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Match result, registered one cycle after the frame
  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_r <= 1'b0;
      hit_r <= '0;
    end else begin
      acc_r <= i_frame.valid;
      if (i_frame.valid) begin
        hit_r <= hit_nxt;
      end
    end
  end

  assign o_prdata       = rdata_r;
  assign o_pready       = ready_r;
  assign o_pslverr      = err_r;
  assign o_accept_valid = acc_r;
  assign o_accept_hits  = hit_r;

  // ==========================================================================
  // Assertions
  logic [10:0] f0_sid;
  assign f0_sid = std_r[0][15:5];

  property p_reserved_zero;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (std_r[0][4] == 1'b0) && (std_r[0][2] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved pattern bits not zero");

  property p_std_mismatch;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_frame.valid && ((f0_sid ^ i_frame.std_id) & mask_std_r[15:5]) != '0
      |=> !hit_r[0];
  endproperty
  a_std_mismatch: assert property (p_std_mismatch)
    else $error("Filter 0 hit despite standard mismatch");

  property p_type_ext;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_frame.valid && mask_std_r[3] && std_r[0][3] && !i_frame.is_ext
      |=> !hit_r[0];
  endproperty
  a_type_ext: assert property (p_type_ext)
    else $error("Extended-only filter took a standard frame");

  property p_type_std;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_frame.valid && mask_std_r[3] && !std_r[0][3] && i_frame.is_ext
      |=> !hit_r[0];
  endproperty
  a_type_std: assert property (p_type_std)
    else $error("Standard-only filter took an extended frame");

  property p_ext_hi;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_frame.valid && i_frame.is_ext &&
      ((std_r[0][1:0] ^ i_frame.ext_id[17:16]) & mask_std_r[1:0]) != '0
      |=> !hit_r[0];
  endproperty
  a_ext_hi: assert property (p_ext_hi)
    else $error("Filter 0 hit despite extended high mismatch");

  property p_ext_lo;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_frame.valid && i_frame.is_ext &&
      ((ext_r[0] ^ i_frame.ext_id[15:0]) & mask_ext_r) != '0
      |=> !hit_r[0];
  endproperty
  a_ext_lo: assert property (p_ext_lo)
    else $error("Filter 0 hit despite extended low mismatch");

  property p_all_open;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_frame.valid && mask_std_r == 16'h0000 && mask_ext_r == 16'h0000
      |=> hit_r == {NUM_FILTERS{1'b1}};
  endproperty
  a_all_open: assert property (p_all_open)
    else $error("Open mask did not accept on every filter");

  property p_write_lands;
    @(posedge i_mclk) disable iff (i_sys_rst)
      wr_en && is_ext && fidx == 4'h1 |=> ext_r[1] == $past(i_pwdata[15:0]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("Extended pattern write lost");

  property p_ready_once;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("APB ready not a single cycle pulse");

  c_write: cover property (@(posedge i_mclk) wr_en && is_std);
  c_hit: cover property (@(posedge i_mclk) o_accept_valid && o_accept_hits[0]);
  c_type: cover property (@(posedge i_mclk)
    i_frame.valid && mask_std_r[3] && i_frame.is_ext);
  c_err: cover property (@(posedge i_mclk) o_pslverr);
endmodule
`default_nettype wire

// ### hdl/caf_match.sv
// One acceptance filter comparator.
// Assumes pattern and mask words come from registers on the same clock.
`timescale 1ns/1ps
`default_nettype none
module caf_match (
  // Pattern
  input  wire logic [15:0]            i_std_pat,
  input  wire logic [15:0]            i_ext_pat,
  // Mask
  input  wire logic [15:0]            i_mask_std,
  input  wire logic [15:0]            i_mask_ext,
  // Frame and result
  input  wire caf_pkg::caf_frame_type i_frame,
  output logic                        o_hit
);
  import caf_pkg::*;
  logic [10:0] sid_pat;
  logic [17:0] eid_pat;
  logic [10:0] sid_msk;
  logic [17:0] eid_msk;
  logic        type_en;
  logic        type_sel;
  logic        sid_ok;
  logic        eid_ok;
  logic        type_ok;

  assign sid_pat  = i_std_pat[15:CAF_STD_ID_LSB];
  assign eid_pat  = {i_std_pat[1:CAF_EXT_HI_LSB], i_ext_pat};
  assign sid_msk  = i_mask_std[15:CAF_STD_ID_LSB];
  assign eid_msk  = {i_mask_std[1:0], i_mask_ext};
  assign type_en  = i_mask_std[CAF_TYPE_BIT];
  assign type_sel = i_std_pat[CAF_TYPE_BIT];
  assign sid_ok   = ((sid_pat ^ i_frame.std_id) & sid_msk) == '0;
  // Extended bits only count for frames that carry them.
  assign eid_ok   = !i_frame.is_ext ||
                    (((eid_pat ^ i_frame.ext_id) & eid_msk) == '0);
  assign type_ok  = !type_en || (type_sel == i_frame.is_ext);
  assign o_hit    = sid_ok && eid_ok && type_ok;
endmodule
`default_nettype wire

// ### hdl/caf_pkg.sv
// Package for the acceptance filter identifier match block.
// Assumes one clock domain and an APB slave register port.
package caf_pkg;

  // ==========================================================================
  // Sizes and register map
  localparam int          CAF_NUM_FILTERS   = 16;
  localparam int          CAF_STD_ID_W      = 11;
  localparam int          CAF_EXT_ID_W      = 18;
  localparam int          CAF_REG_W         = 16;
  // Filter n standard pattern at byte 0x000 + 8*n, extended at 0x004 + 8*n.
  localparam logic [11:0] CAF_STD_OFS       = 12'h000;
  localparam logic [11:0] CAF_EXT_OFS       = 12'h004;
  localparam logic [11:0] CAF_FILTER_STRIDE = 12'h008;
  // Standard and extended mask registers, then the match result register.
  localparam logic [11:0] CAF_MASK_STD_OFS  = 12'h080;
  localparam logic [11:0] CAF_MASK_EXT_OFS  = 12'h084;
  localparam logic [11:0] CAF_RESULT_OFS    = 12'h088;

  // ==========================================================================
  // Field positions in the standard pattern register
  localparam int CAF_STD_ID_LSB  = 5;
  localparam int CAF_TYPE_BIT    = 3;
  localparam int CAF_EXT_HI_LSB  = 0;
  // Bits 15..5, 3, 1..0 are writable; 4 and 2 read as zero.
  localparam logic [15:0] CAF_STD_WMASK = 16'hFFEB;

  // Reset values (contents are unknown at power-on; zero chosen).
  localparam logic [15:0] CAF_PATTERN_RST = 16'h0000;

  // ==========================================================================
  // Received frame identifier from the protocol engine
  typedef struct packed {
    logic        valid;
    logic        is_ext;
    logic [10:0] std_id;
    logic [17:0] ext_id;
  } caf_frame_type;

endpackage
